/* File: inc/bps_pkg.sv */
// Constants, states and carrier structs of the boot and power-state sequencer
// Assumes a single 200 MHz clock; sibling blocks report done levels and command pulses
package bps_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned POR_DELAY_MS = 50;
  localparam int unsigned STARTUP_MAX_MS = 60;
  localparam int unsigned POR_DELAY_CYC = POR_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned STARTUP_MAX_CYC = STARTUP_MAX_MS * 1000 * CLK_MHZ;
  localparam int unsigned LOW_POWER_OSC_MHZ = 16;
  localparam int unsigned CNT_W = 24;
  // ----------------------------------------
  // Fields
  // ----------------------------------------
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned MATRIX_PINS = 4;
  localparam logic [3:0] MATRIX_DEFAULT = 4'hF;
  localparam logic [7:0] LOADER_VERSION = 8'h01; // Arbitrary value
  localparam logic [7:0] HW_VERSION = 8'h01;     // Arbitrary value
  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h00000000;
  localparam logic [7:0] CLK_KEEP_RESET = 8'h00;

  typedef enum logic [2:0] {
    BPS_RESET, BPS_INIT, BPS_CMD, BPS_ACTIVE, BPS_SLEEP
  } bps_state_t;

  // Host commands decoded by the serial slave, one-cycle pulses
  typedef struct packed {
    logic mem_wr;
    logic mem_rd;
    logic dsp_mem_wr;
    logic dsp_mem_rd;
    logic dsp_enable;
    logic dsp_disable;
    logic start_app;
    logic get_version;
    logic reset;
    logic reconfig;
    logic status_read;
  } bps_host_cmd_t;

  // Init step completion levels
  typedef struct packed {
    logic supply_ok;
    logic power_mgmt_done;
    logic otp_done;
  } bps_init_done_t;

  // Power and clock enables
  typedef struct packed {
    logic por_active;
    logic supply_meas;
    logic power_mgmt_cfg;
    logic otp_load;
    logic osc_low_power_sel;
    logic cpu_run;
    logic boot_rom;
    logic spi_slave_en;
    logic logic_pwr;
    logic retain_pwr;
  } bps_power_t;

  // Reset state: only the power-on reset cell stays on
  localparam bps_power_t POWER_RESET = '{por_active: 1'b1, default: 1'b0};
endpackage : bps_pkg

/* File: core/bps_sequencer.sv */
// Boot and power-state sequencer: Reset, Init, command handler, Active, Sleep
// Assumes synchronous inputs; serial slave decodes host commands into pulses
module bps_sequencer #(
  parameter int unsigned POR_CYC = bps_pkg::POR_DELAY_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic supply_low_i,
  input wire logic brownout_detector_i,
  input wire logic brownout_reset_en_i,
  input wire logic fw_reset_i,
  input wire bps_pkg::bps_init_done_t init_done_i,
  input wire logic service_request_pin_i,
  input wire bps_pkg::bps_host_cmd_t host_cmd_i,
  input wire logic [bps_pkg::ADDR_W-1:0] start_addr_i,
  input wire logic [7:0] block_busy_i,
  input wire logic sleep_cmd_i,
  input wire logic [7:0] clk_keep_i,
  input wire logic wake_irq_i,
  input wire logic host_service_request_line_i,
  input wire logic host_int_i,
  output bps_pkg::bps_state_t state_o,
  output bps_pkg::bps_power_t power_o,
  output logic [bps_pkg::MATRIX_PINS-1:0] pin_switch_matrix_o,
  output logic matrix_apply_o,
  output logic mem_wr_o,
  output logic mem_rd_o,
  output logic dsp_mem_wr_o,
  output logic dsp_mem_rd_o,
  output logic dsp_en_o,
  output logic exec_start_o,
  output logic [bps_pkg::ADDR_W-1:0] exec_addr_o,
  output logic version_valid_o,
  output logic [15:0] version_o,
  output logic [7:0] block_clk_en_o,
  output logic [7:0] block_pwr_en_o,
  output logic host_wake_o
);
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  bps_pkg::bps_state_t state_q, state_d;
  logic [bps_pkg::CNT_W-1:0] por_cnt_q, por_cnt_d;
  localparam logic [bps_pkg::CNT_W-1:0] POR_LAST = bps_pkg::CNT_W'(POR_CYC - 1);

  wire force_reset = supply_low_i | (brownout_detector_i & brownout_reset_en_i) | fw_reset_i;
  wire por_done = (por_cnt_q == POR_LAST);
  wire init_done = init_done_i.supply_ok & init_done_i.power_mgmt_done & init_done_i.otp_done;
  wire in_cmd = (state_q == bps_pkg::BPS_CMD);
  wire in_active = (state_q == bps_pkg::BPS_ACTIVE);
  wire wake = wake_irq_i | host_cmd_i.status_read;

  always_comb begin
    state_d = state_q;
    por_cnt_d = por_cnt_q;
    case (state_q)
      bps_pkg::BPS_RESET: begin
        if (!por_done) begin
          por_cnt_d = por_cnt_q + 1'b1;
        end else begin
          state_d = bps_pkg::BPS_INIT;
        end
      end
      bps_pkg::BPS_INIT: begin
        if (init_done && service_request_pin_i) begin
          state_d = bps_pkg::BPS_CMD;
        end
      end
      bps_pkg::BPS_CMD: begin
        if (host_cmd_i.reset) begin
          state_d = bps_pkg::BPS_RESET;
        end else if (host_cmd_i.start_app) begin
          state_d = bps_pkg::BPS_ACTIVE;
        end
      end
      bps_pkg::BPS_ACTIVE: begin
        if (sleep_cmd_i) begin
          state_d = bps_pkg::BPS_SLEEP;
        end
      end
      bps_pkg::BPS_SLEEP: begin
        if (wake) begin
          state_d = bps_pkg::BPS_ACTIVE;
        end
      end
      default: begin
        state_d = bps_pkg::BPS_RESET;
      end
    endcase
    if (force_reset) begin
      state_d = bps_pkg::BPS_RESET;
    end
    if (state_d == bps_pkg::BPS_RESET && state_q != bps_pkg::BPS_RESET) begin
      por_cnt_d = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= bps_pkg::BPS_RESET;
      por_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      por_cnt_q <= por_cnt_d;
    end
  end

  // ----------------------------------------
  // Power, clocks and pins
  // ----------------------------------------
  wire in_init = (state_q == bps_pkg::BPS_INIT);
  wire in_sleep = (state_q == bps_pkg::BPS_SLEEP);
  bps_pkg::bps_power_t power_d;
  always_comb begin
    power_d = '0;
    power_d.por_active = 1'b1;
    power_d.supply_meas = (state_d == bps_pkg::BPS_INIT);
    power_d.power_mgmt_cfg = (state_d == bps_pkg::BPS_INIT);
    power_d.otp_load = (state_d == bps_pkg::BPS_INIT);
    power_d.osc_low_power_sel = (state_d == bps_pkg::BPS_INIT);
    power_d.cpu_run = (state_d == bps_pkg::BPS_CMD) || (state_d == bps_pkg::BPS_ACTIVE);
    power_d.boot_rom = (state_d == bps_pkg::BPS_CMD);
    power_d.spi_slave_en = (state_d == bps_pkg::BPS_CMD) || (state_d == bps_pkg::BPS_ACTIVE);
    power_d.logic_pwr = (state_d == bps_pkg::BPS_CMD) || (state_d == bps_pkg::BPS_ACTIVE);
    power_d.retain_pwr = (state_d != bps_pkg::BPS_RESET);
  end

  wire [7:0] clk_en_d = (state_d == bps_pkg::BPS_ACTIVE) ? block_busy_i :
                        (state_d == bps_pkg::BPS_SLEEP) ? clk_keep_i :
                        '0;
  wire [7:0] pwr_en_d = (state_d == bps_pkg::BPS_ACTIVE) ? block_busy_i : 8'h00;
  wire enter_cmd = (state_d == bps_pkg::BPS_CMD) && !in_cmd;
  wire reapply = enter_cmd || (in_cmd && host_cmd_i.reconfig);

  // ----------------------------------------
  // Command handling
  // ----------------------------------------
  logic dsp_en_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || state_d == bps_pkg::BPS_RESET) begin
      state_o <= bps_pkg::BPS_RESET;
      power_o <= bps_pkg::POWER_RESET;
      pin_switch_matrix_o <= '0;
      matrix_apply_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_rd_o <= 1'b0;
      dsp_mem_wr_o <= 1'b0;
      dsp_mem_rd_o <= 1'b0;
      dsp_en_q <= 1'b0;
      exec_start_o <= 1'b0;
      exec_addr_o <= bps_pkg::ADDR_RESET;
      version_valid_o <= 1'b0;
      version_o <= '0;
      block_clk_en_o <= bps_pkg::CLK_KEEP_RESET;
      block_pwr_en_o <= 8'h00;
      host_wake_o <= 1'b0;
    end else begin
      state_o <= state_d;
      power_o <= power_d;
      if (reapply) begin
        pin_switch_matrix_o <= bps_pkg::MATRIX_DEFAULT;
      end
      matrix_apply_o <= reapply;
      mem_wr_o <= in_cmd & host_cmd_i.mem_wr;
      mem_rd_o <= in_cmd & host_cmd_i.mem_rd;
      dsp_mem_wr_o <= in_cmd & host_cmd_i.dsp_mem_wr;
      dsp_mem_rd_o <= in_cmd & host_cmd_i.dsp_mem_rd;
      if (in_cmd && host_cmd_i.dsp_enable) begin
        dsp_en_q <= 1'b1;
      end else if (in_cmd && host_cmd_i.dsp_disable) begin
        dsp_en_q <= 1'b0;
      end
      exec_start_o <= in_cmd & host_cmd_i.start_app & ~host_cmd_i.reset;
      if (in_cmd && host_cmd_i.start_app) begin
        exec_addr_o <= start_addr_i;
      end
      version_valid_o <= in_cmd & host_cmd_i.get_version;
      if (in_cmd && host_cmd_i.get_version) begin
        version_o <= {bps_pkg::LOADER_VERSION, bps_pkg::HW_VERSION};
      end
      block_clk_en_o <= clk_en_d;
      block_pwr_en_o <= pwr_en_d;
      host_wake_o <= in_active & (host_service_request_line_i | host_int_i);
    end
  end
  assign dsp_en_o = dsp_en_q;
  wire cmd_live = in_cmd && !host_cmd_i.reset && !force_reset;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_force_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    force_reset |=> state_q == bps_pkg::BPS_RESET) else $error("forced reset not taken");
  chk_init_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == bps_pkg::BPS_INIT && !$past(in_init)) |-> $past(state_q) == bps_pkg::BPS_RESET)
    else $error("init entered from wrong state");
  chk_request_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_init && !service_request_pin_i && !force_reset) |=> in_init) else $error("init left while request low");
  chk_slow_clock: assert property (@(posedge clk_i) disable iff (rst_i)
    in_init |-> power_o.osc_low_power_sel) else $error("init not on low power clock");
  chk_por_time: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_init && !$past(in_init)) |-> $past(por_done)) else $error("init before reset delay");
  chk_cmd_spi: assert property (@(posedge clk_i) disable iff (rst_i)
    in_cmd |-> (power_o.spi_slave_en && power_o.boot_rom && pin_switch_matrix_o == bps_pkg::MATRIX_DEFAULT))
    else $error("command handler without slave port");
  chk_active_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_active && !$past(in_active)) |-> ($past(in_sleep) || ($past(in_cmd) && $past(host_cmd_i.start_app))))
    else $error("active entered wrongly");
  chk_sleep_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_sleep && !$past(in_sleep)) |-> $past(sleep_cmd_i) && $past(in_active)) else $error("sleep entered wrongly");
  chk_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_sleep && wake && !force_reset) |=> in_active) else $error("wake ignored");
  chk_host_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_cmd && host_cmd_i.reset) |=> state_q == bps_pkg::BPS_RESET) else $error("host reset ignored");
  chk_version: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_cmd && host_cmd_i.get_version && !host_cmd_i.reset && !force_reset) |=> version_valid_o &&
    version_o == {bps_pkg::LOADER_VERSION, bps_pkg::HW_VERSION}) else $error("version not returned");

  // ----------------------------------------
  // Output checks
  // ----------------------------------------
  chk_reset_power: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == bps_pkg::BPS_RESET |-> power_o == bps_pkg::POWER_RESET)
    else $error("reset state powers more than reset cell");

  chk_reset_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == bps_pkg::BPS_RESET |-> !dsp_en_o && !exec_start_o && block_clk_en_o == '0 && block_pwr_en_o == '0)
    else $error("outputs active in reset");

  chk_por_count: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == bps_pkg::BPS_RESET |-> por_cnt_q <= POR_LAST)
    else $error("reset delay counter overrun");

  chk_init_power: assert property (@(posedge clk_i) disable iff (rst_i)
    in_init |-> power_o.supply_meas && power_o.power_mgmt_cfg && power_o.otp_load && !power_o.logic_pwr)
    else $error("init power set wrong");

  chk_cmd_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_cmd && !$past(in_cmd)) |-> $past(in_init) && $past(service_request_pin_i))
    else $error("command handler entered wrongly");

  chk_mem_ops: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_live |=> mem_wr_o == $past(host_cmd_i.mem_wr) && mem_rd_o == $past(host_cmd_i.mem_rd))
    else $error("memory command not carried out");

  chk_dsp_mem: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_live |=> dsp_mem_wr_o == $past(host_cmd_i.dsp_mem_wr) && dsp_mem_rd_o == $past(host_cmd_i.dsp_mem_rd))
    else $error("signal processor memory command not carried out");

  chk_mem_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
    !in_cmd |=> !mem_wr_o && !mem_rd_o && !dsp_mem_wr_o && !dsp_mem_rd_o)
    else $error("memory command outside command handler");

  chk_dsp_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_live && host_cmd_i.dsp_enable) |=> dsp_en_o)
    else $error("signal processor not enabled");

  chk_dsp_disable: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_live && host_cmd_i.dsp_disable && !host_cmd_i.dsp_enable) |=> !dsp_en_o)
    else $error("signal processor not disabled");

  chk_exec_start: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_live && host_cmd_i.start_app) |=> exec_start_o && exec_addr_o == $past(start_addr_i))
    else $error("start address not taken");

  chk_cmd_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
    !in_cmd |=> !exec_start_o && !version_valid_o)
    else $error("command answered outside command handler");

  chk_matrix_apply: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_live && host_cmd_i.reconfig) |=> matrix_apply_o && pin_switch_matrix_o == bps_pkg::MATRIX_DEFAULT)
    else $error("pin matrix not reapplied");

  chk_active_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    in_active |-> block_clk_en_o == $past(block_busy_i) && block_pwr_en_o == $past(block_busy_i))
    else $error("idle block left running");

  chk_host_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_active && $past(in_active)) |-> host_wake_o == ($past(host_service_request_line_i) || $past(host_int_i)))
    else $error("host line not followed");

  chk_sleep_clocks: assert property (@(posedge clk_i) disable iff (rst_i)
    in_sleep |-> block_clk_en_o == $past(clk_keep_i) && block_pwr_en_o == '0)
    else $error("sleep clocks wrong");

  chk_sleep_power: assert property (@(posedge clk_i) disable iff (rst_i)
    in_sleep |-> power_o.retain_pwr && !power_o.cpu_run && !power_o.logic_pwr)
    else $error("sleep power wrong");
endmodule : bps_sequencer

/* File: sim/bps_host_model.sv */
// Host controller model: serial bus master issuing decoded host commands
// Assumes commands reach the sequencer as one-cycle pulses on clk_i
module bps_host_model (
  input wire logic clk_i,
  output logic req_pin_o,
  output bps_pkg::bps_host_cmd_t cmd_o,
  output logic [31:0] addr_o,
  output logic line_o,
  output logic int_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_pin_o = 1'b0;
    cmd_o = '0;
    addr_o = 32'h0;
    line_o = 1'b0;
    int_o = 1'b0;
  end
  // ----------------------------------------
  // Host actions
  // ----------------------------------------
  task automatic send(input int idx, input logic [31:0] addr);
    @(posedge clk_i);
    cmd_o <= 11'h400 >> idx;
    addr_o <= addr;
    @(posedge clk_i);
    cmd_o <= '0;
    addr_o <= ~addr;
  endtask : send
  task automatic set_req(input logic v);
    @(posedge clk_i);
    req_pin_o <= v;
  endtask : set_req
  task automatic lines(input logic l, input logic i);
    @(posedge clk_i);
    line_o <= l;
    int_o <= i;
  endtask : lines
endmodule : bps_host_model

/* File: sim/bps_sequencer_tb.sv */
// Self-checking bench of the boot and power-state sequencer
// Assumes a short power-on count and the host model on the command side
module bps_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned POR = 16;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic supply_low = 1'b0, brownout = 1'b0, brownout_en = 1'b0, fw_rst = 1'b0, sleep_cmd = 1'b0, wake = 1'b0;
  bps_pkg::bps_init_done_t idone = 3'h7;
  logic [7:0] busy = 8'h00, keep = 8'h3C;
  logic req_pin, line, hint, apply, mwr, mrd, dwr, drd, den, xst, ver_v, hwake;
  bps_pkg::bps_host_cmd_t hcmd;
  logic [31:0] saddr, xaddr;
  bps_pkg::bps_state_t st;
  bps_pkg::bps_power_t pw;
  logic [3:0] mtx;
  logic [15:0] ver;
  logic [7:0] cen, pen;
  int error_cnt = 0;
  int n_tests = 0;
  always #2.5 clk_i = ~clk_i;
  bps_host_model hm (.clk_i(clk_i), .req_pin_o(req_pin), .cmd_o(hcmd), .addr_o(saddr), .line_o(line), .int_o(hint));
  bps_sequencer #(.POR_CYC(POR)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .supply_low_i(supply_low), .brownout_detector_i(brownout),
    .brownout_reset_en_i(brownout_en), .fw_reset_i(fw_rst), .init_done_i(idone),
    .service_request_pin_i(req_pin), .host_cmd_i(hcmd), .start_addr_i(saddr), .block_busy_i(busy),
    .sleep_cmd_i(sleep_cmd), .clk_keep_i(keep), .wake_irq_i(wake),
    .host_service_request_line_i(line), .host_int_i(hint), .state_o(st), .power_o(pw),
    .pin_switch_matrix_o(mtx), .matrix_apply_o(apply), .mem_wr_o(mwr), .mem_rd_o(mrd),
    .dsp_mem_wr_o(dwr), .dsp_mem_rd_o(drd), .dsp_en_o(den), .exec_start_o(xst),
    .exec_addr_o(xaddr), .version_valid_o(ver_v), .version_o(ver), .block_clk_en_o(cen),
    .block_pwr_en_o(pen), .host_wake_o(hwake)
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic wait_st(input bps_pkg::bps_state_t s, input int lim, output int n);
    n = 0;
    while (st !== s && n < lim) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check("state_wait", st, s);
    if (st !== s) end_of_test();
  endtask : wait_st
  // Pulse one of fw reset, brown-out, low supply, sleep, wake
  task automatic pulse_in(input int k);
    @(posedge clk_i);
    {fw_rst, brownout, supply_low, sleep_cmd, wake} <= 5'h10 >> k;
    @(posedge clk_i);
    {fw_rst, brownout, supply_low, sleep_cmd, wake} <= 5'h00;
    #1;
  endtask : pulse_in
  task automatic boot(input logic act);
    int n;
    wait_st(bps_pkg::BPS_INIT, POR + 4, n);
    wait_st(bps_pkg::BPS_CMD, 4, n);
    if (act) hm.send(6, 32'h00000000);
    #1;
  endtask : boot
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_por();
    int n;
    cyc(2);
    check("st_reset", st, bps_pkg::BPS_RESET);
    check("pw_reset", pw, 10'h200);
    wait_st(bps_pkg::BPS_INIT, POR + 4, n);
    check("por_len", n, POR - 2);
    check("pw_init", {pw.supply_meas, pw.power_mgmt_cfg, pw.otp_load, pw.osc_low_power_sel, pw.logic_pwr}, 5'h1E);
  endtask : t_por
  task automatic t_init();
    int n;
    cyc(8);
    check("req_hold", st, bps_pkg::BPS_INIT);
    hm.send(0, 32'h00000000);
    #1;
    check("init_refuse", mwr, 1'b0);
    hm.set_req(1'b1);
    wait_st(bps_pkg::BPS_CMD, 4, n);
    check("cmd_apply", apply, 1'b1);
    check("cmd_pwr", {mtx, pw.spi_slave_en, pw.boot_rom}, 6'h3F);
  endtask : t_init
  task automatic t_cmds();
    for (int i = 0; i < 4; i++) begin
      hm.send(i, 32'h00000000);
      #1;
      check("mem_ops", {mwr, mrd, dwr, drd}, 4'h8 >> i);
    end
    hm.send(4, 32'h00000000);
    #1;
    check("dsp_on", den, 1'b1);
    hm.send(5, 32'h00000000);
    #1;
    check("dsp_off", den, 1'b0);
    hm.send(7, 32'h00000000);
    #1;
    check("ver", {ver_v, ver}, {1'b1, bps_pkg::LOADER_VERSION, bps_pkg::HW_VERSION});
    hm.send(9, 32'h00000000);
    #1;
    check("reconf", {apply, mtx}, 5'h1F);
    check("cmd_stay", st, bps_pkg::BPS_CMD);
  endtask : t_cmds
  task automatic t_start();
    hm.send(6, 32'hA5C30F18);
    #1;
    check("exec_go", {xst, st}, {1'b1, bps_pkg::BPS_ACTIVE});
    check("exec_addr", xaddr, 32'hA5C30F18);
    cyc(1);
    check("exec_hold", {xst, xaddr}, {1'b0, 32'hA5C30F18});
  endtask : t_start
  task automatic t_active();
    @(posedge clk_i) busy <= 8'h5A;
    cyc(2);
    check("act_gate", {cen, pen}, 16'h5A5A);
    hm.lines(1'b1, 1'b0);
    cyc(2);
    check("host_line", hwake, 1'b1);
    hm.lines(1'b0, 1'b1);
    cyc(2);
    check("host_int", hwake, 1'b1);
    hm.lines(1'b0, 1'b0);
    pulse_in(3);
    check("sleep_st", st, bps_pkg::BPS_SLEEP);
    check("sleep_pw", {cen, pw.retain_pwr, pw.cpu_run}, {keep, 2'h2});
    pulse_in(4);
    check("wake_irq", st, bps_pkg::BPS_ACTIVE);
    pulse_in(3);
    hm.send(10, 32'h00000000);
    #1;
    check("wake_status", st, bps_pkg::BPS_ACTIVE);
  endtask : t_active
  task automatic t_resets();
    pulse_in(0);
    check("fw_rst", st, bps_pkg::BPS_RESET);
    boot(1'b1);
    pulse_in(1);
    cyc(2);
    check("brownout_masked", st, bps_pkg::BPS_ACTIVE);
    @(posedge clk_i) brownout_en <= 1'b1;
    pulse_in(1);
    check("brownout_rst", st, bps_pkg::BPS_RESET);
    boot(1'b0);
    pulse_in(2);
    check("supply_rst", st, bps_pkg::BPS_RESET);
    boot(1'b0);
    hm.send(8, 32'h00000000);
    #1;
    check("host_rst", st, bps_pkg::BPS_RESET);
  endtask : t_resets
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_por();
    t_init();
    t_cmds();
    t_start();
    t_active();
    t_resets();
    end_of_test();
  end
endmodule : bps_sequencer_tb
